// [wdu_pkg.sv]
// Constants, register map, field layouts and types of the word divide unit.
// Assumes a single 25 MHz clock domain and an AXI4-Lite master with 32-bit data.
//
// What this block does
// [RL1] An instruction with primary opcode 31 and extended opcode 491 is a signed word divide.
// [RL2] An instruction with primary opcode 31 and extended opcode 459 is an unsigned word divide.
// [RL3] Bits 6-10 name the destination, 11-15 the dividend, 16-20 the divisor; quotient goes to destination.
// [RL4] Bit 21 selects overflow enable and bit 31 selects record, giving four variants per divide.
// [RL5] The signed divide treats dividend, divisor and quotient as two's-complement 32-bit values.
// [RL6] A signed overflow, such as most negative by minus one, may leave any quotient value.
// [RL7] The unsigned divide treats dividend, divisor and quotient as unsigned 32-bit values.
// [RL8] An unsigned divide by zero may leave any quotient value.
// [RL9] With record set, the unsigned divide sets the sign flags by a signed compare of quotient to zero.
// [RL10] With overflow enable set the summary and overflow flags update; otherwise they stay unchanged.
// [RL11] With record set the condition field zero flags update; otherwise that field stays unchanged.
// [RL12] No divide variant ever changes the carry flag.
// [RL13] With overflow enable, overflow is set on zero divisor or signed overflow, else cleared; summary is sticky.
// [RL14] With record set, the field's summary flag copies the summary flag after this instruction's update.
package wdu_pkg;

  // ****************************************
  // Bus and register map
  // ****************************************
  localparam int          ADDR_W      = 12;
  localparam logic [11:0] ADDR_INSN   = 12'h000;
  localparam logic [11:0] ADDR_STAT   = 12'h004;
  localparam logic [11:0] ADDR_XER    = 12'h008;
  localparam logic [11:0] ADDR_CR0    = 12'h00c;
  localparam logic [11:0] ADDR_ISTAT  = 12'h010;
  localparam logic [11:0] ADDR_IMASK  = 12'h014;
  localparam logic [4:0]  GR_PAGE     = 5'h01;   // Address bits 11:7 of the general registers
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ****************************************
  // Instruction encoding
  // ****************************************
  localparam logic [5:0] OPC_PRIMARY = 6'h1f;    // 31
  localparam logic [8:0] XO_DIVW     = 9'h1eb;   // 491
  localparam logic [8:0] XO_DIVWU    = 9'h1cb;   // 459

  // ****************************************
  // Flag layouts and reset values
  // ****************************************
  localparam int        XER_LSB    = 29;         // Summary 31, overflow 30, carry 29
  localparam logic [2:0] XER_RST   = 3'h0;
  localparam logic [3:0] CR_RST    = 4'h0;
  localparam int        EV_DONE    = 0;
  localparam int        EV_OVF     = 1;
  localparam int        EV_ILL     = 2;
  localparam int        EV_W       = 3;
  localparam logic [2:0] IMASK_RST = 3'h0;
  localparam int        STAT_BUSY  = 0;

  // ****************************************
  // Timing
  // ****************************************
  localparam int        DIV_STEPS = 32;
  localparam logic [5:0] STEP_LAST = 6'h1f;

  // ****************************************
  // Types
  // ****************************************
  // Instruction word, bit 0 of the encoding is the msb here
  typedef struct packed {
    logic [5:0] primary;
    logic [4:0] dest_register_index;
    logic [4:0] dividend_register_index;
    logic [4:0] divisor_register_index;
    logic       ovf_enable;
    logic [8:0] xo;
    logic       record_selector;
  } wdu_insn_s;

  typedef struct packed {
    logic summary_ovf;
    logic result_too_big_flag;
    logic carry_flag;
  } wdu_xer_s;

  typedef struct packed {
    logic negative_result_flag;
    logic positive_result_flag;
    logic zero_result_flag;
    logic summary_ovf;
  } wdu_cr_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CALC = 3'b010,
    ST_FIN  = 3'b100
  } wdu_state_e;

endpackage

// [wdu_word_divide_unit.sv]
// Word divide unit: general registers, flag registers and a 32-step divider.
// Assumes an AXI4-Lite master on aclk and that ce is high while the bus is active.
`timescale 1ns/1ps
`default_nettype none

module wdu_word_divide_unit (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic                       ce,
  input  wire logic [wdu_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [wdu_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  output logic                            irq
);

  // ****************************************
  // State
  // ****************************************
  logic [31:0]                general_register [32];
  logic [wdu_pkg::ADDR_W-1:0] aw_addr_reg;
  logic [31:0]                w_data_reg;
  logic [3:0]                 w_strb_reg;
  logic                       aw_held_reg, w_held_reg, bvalid_reg, rvalid_reg;
  logic [1:0]                 bresp_reg, rresp_reg;
  logic [31:0]                rdata_reg;
  wdu_pkg::wdu_insn_s         insn_reg;
  wdu_pkg::wdu_state_e        state_reg;
  logic [5:0]                 step_reg;
  logic [31:0]                rem_reg, quo_reg, dvs_mag_reg, dvd_raw_reg, dvs_raw_reg;
  logic                       signed_reg, neg_reg;
  wdu_pkg::wdu_xer_s          xer_reg;
  wdu_pkg::wdu_cr_s           cr_reg;
  logic [wdu_pkg::EV_W-1:0]   istat_reg, imask_reg;

  // Byte-lane merge of a bus write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ****************************************
  // Bus handshakes and write decode
  // ****************************************
  assign s_axi_awready = ce && !aw_held_reg;
  assign s_axi_wready  = ce && !w_held_reg;
  assign s_axi_arready = ce && !rvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;

  wire        aw_fire = s_axi_awvalid && s_axi_awready;
  wire        w_fire  = s_axi_wvalid && s_axi_wready;
  wire        ar_fire = s_axi_arvalid && s_axi_arready;
  wire        wr_go   = ce && aw_held_reg && w_held_reg && !bvalid_reg;
  wire        wa_gr   = aw_addr_reg[11:7] == wdu_pkg::GR_PAGE;
  wire        wa_ok   = wa_gr || aw_addr_reg == wdu_pkg::ADDR_INSN ||
                        aw_addr_reg == wdu_pkg::ADDR_STAT || aw_addr_reg == wdu_pkg::ADDR_XER ||
                        aw_addr_reg == wdu_pkg::ADDR_CR0 || aw_addr_reg == wdu_pkg::ADDR_ISTAT ||
                        aw_addr_reg == wdu_pkg::ADDR_IMASK;
  wire        wr_insn = wr_go && aw_addr_reg == wdu_pkg::ADDR_INSN;
  wire        wr_xer  = wr_go && aw_addr_reg == wdu_pkg::ADDR_XER;
  wire        wr_cr   = wr_go && aw_addr_reg == wdu_pkg::ADDR_CR0;
  wire        wr_ist  = wr_go && aw_addr_reg == wdu_pkg::ADDR_ISTAT;
  wire        wr_imk  = wr_go && aw_addr_reg == wdu_pkg::ADDR_IMASK;
  wire        wr_gr   = wr_go && wa_gr;
  wire [31:0] wr_word = merge(32'h0, w_data_reg, w_strb_reg);

  // ****************************************
  // Instruction decode
  // ****************************************
  wdu_pkg::wdu_insn_s insn_new;
  assign insn_new = merge(insn_reg, w_data_reg, w_strb_reg);
  wire is_divw  = insn_new.primary == wdu_pkg::OPC_PRIMARY
                  && insn_new.xo == wdu_pkg::XO_DIVW;      // [RL1]
  wire is_divwu = insn_new.primary == wdu_pkg::OPC_PRIMARY
                  && insn_new.xo == wdu_pkg::XO_DIVWU;     // [RL2]
  wire idle     = state_reg == wdu_pkg::ST_IDLE;
  wire issue    = wr_insn && idle && (is_divw || is_divwu);
  wire illegal  = wr_insn && idle && !(is_divw || is_divwu);

  // Operand fetch, register indices from the instruction fields
  wire [31:0] opa = general_register[insn_new.dividend_register_index];  // [RL3]
  wire [31:0] opb = general_register[insn_new.divisor_register_index];   // [RL3]
  wire [31:0] opa_mag = (is_divw && opa[31]) ? 32'(-opa) : opa;          // [RL5] [RL7]
  wire [31:0] opb_mag = (is_divw && opb[31]) ? 32'(-opb) : opb;

  // ****************************************
  // Divider step and result
  // ****************************************
  wire [32:0] rem_sh  = {rem_reg, quo_reg[31]};
  wire [32:0] diff    = rem_sh - {1'b0, dvs_mag_reg};
  wire        fin     = ce && state_reg == wdu_pkg::ST_FIN;
  // Quotient of zero divisor or signed overflow is left as computed
  wire [31:0] quot    = neg_reg ? 32'(-quo_reg) : quo_reg;                  // [RL6] [RL8]
  wire        s_ovf   = signed_reg && dvd_raw_reg == 32'h80000000
                        && dvs_raw_reg == 32'hffffffff;
  wire        ovf     = dvs_raw_reg == 32'h0 || s_ovf;                      // [RL13]

  // Flag results of a finishing divide
  wdu_pkg::wdu_xer_s xer_sw, xer_next;
  wdu_pkg::wdu_cr_s  cr_sw, cr_next;
  assign xer_sw = wr_xer ? wr_word[31:wdu_pkg::XER_LSB] : xer_reg;
  assign cr_sw  = wr_cr ? wr_word[3:0] : cr_reg;
  always_comb begin
    xer_next = xer_sw;
    cr_next  = cr_sw;
    if (fin && insn_reg.ovf_enable) begin                                   // [RL4] [RL10]
      xer_next.result_too_big_flag = ovf;                                   // [RL13]
      xer_next.summary_ovf         = xer_sw.summary_ovf || ovf;             // [RL13]
    end
    if (fin && insn_reg.record_selector) begin                              // [RL4] [RL11]
      cr_next.negative_result_flag = quot[31];                              // [RL9]
      cr_next.positive_result_flag = !quot[31] && quot != 32'h0;            // [RL9]
      cr_next.zero_result_flag     = quot == 32'h0;                         // [RL9]
      cr_next.summary_ovf          = xer_next.summary_ovf;                  // [RL14]
    end
    xer_next.carry_flag = xer_sw.carry_flag;                                // [RL12]
  end

  // Sticky events, set beats a write-one clear
  wire [wdu_pkg::EV_W-1:0] ev      = {illegal, fin && ovf, fin};
  wire [wdu_pkg::EV_W-1:0] ist_clr = wr_ist ? wr_word[wdu_pkg::EV_W-1:0] : '0;
  assign irq = |(istat_reg & imask_reg);

  // ****************************************
  // Read decode
  // ****************************************
  wire [wdu_pkg::ADDR_W-1:0] ra = s_axi_araddr;
  logic [31:0] rd_word;
  logic        rd_ok;
  always_comb begin
    rd_ok   = 1'b1;
    rd_word = 32'h0;
    if (ra[11:7] == wdu_pkg::GR_PAGE) begin
      rd_word = general_register[ra[6:2]];
    end else if (ra == wdu_pkg::ADDR_INSN) begin
      rd_word = insn_reg;
    end else if (ra == wdu_pkg::ADDR_STAT) begin
      rd_word[wdu_pkg::STAT_BUSY] = !idle;
    end else if (ra == wdu_pkg::ADDR_XER) begin
      rd_word[31:wdu_pkg::XER_LSB] = xer_reg;
    end else if (ra == wdu_pkg::ADDR_CR0) begin
      rd_word[3:0] = cr_reg;
    end else if (ra == wdu_pkg::ADDR_ISTAT) begin
      rd_word[wdu_pkg::EV_W-1:0] = istat_reg;
    end else if (ra == wdu_pkg::ADDR_IMASK) begin
      rd_word[wdu_pkg::EV_W-1:0] = imask_reg;
    end else begin
      rd_ok = 1'b0;
    end
  end

  // ****************************************
  // Bus slave registers
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      rvalid_reg  <= 1'b0;
      bresp_reg   <= wdu_pkg::RESP_OKAY;
      rresp_reg   <= wdu_pkg::RESP_OKAY;
      rdata_reg   <= 32'h0;
      aw_addr_reg <= '0;
      w_data_reg  <= 32'h0;
      w_strb_reg  <= 4'h0;
    end else if (ce) begin
      if (aw_fire) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_fire) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wa_ok ? wdu_pkg::RESP_OKAY : wdu_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
      if (ar_fire) begin
        rvalid_reg <= 1'b1;
        rdata_reg  <= rd_word;
        rresp_reg  <= rd_ok ? wdu_pkg::RESP_OKAY : wdu_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // Flags, events and mask
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xer_reg   <= wdu_pkg::XER_RST;
      cr_reg    <= wdu_pkg::CR_RST;
      istat_reg <= '0;
      imask_reg <= wdu_pkg::IMASK_RST;
    end else if (ce) begin
      xer_reg   <= xer_next;
      cr_reg    <= cr_next;
      istat_reg <= (istat_reg & ~ist_clr) | ev;
      if (wr_imk) begin
        imask_reg <= wr_word[wdu_pkg::EV_W-1:0];
      end
    end
  end

  // ****************************************
  // Divider sequencer
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= wdu_pkg::ST_IDLE;
      insn_reg  <= '0;
      step_reg  <= 6'h0;
    end else if (ce) begin
      case (state_reg)
        wdu_pkg::ST_IDLE: begin
          if (issue) begin
            insn_reg  <= insn_new;
            step_reg  <= 6'h0;
            state_reg <= wdu_pkg::ST_CALC;
          end
        end
        wdu_pkg::ST_CALC: begin
          step_reg <= step_reg + 6'h1;
          if (step_reg == wdu_pkg::STEP_LAST) begin
            state_reg <= wdu_pkg::ST_FIN;
          end
        end
        default: state_reg <= wdu_pkg::ST_IDLE;
      endcase
    end
  end

  // Operand latch and restoring divide steps
  always_ff @(posedge aclk) begin
    if (ce && issue) begin
      rem_reg     <= 32'h0;
      quo_reg     <= opa_mag;
      dvs_mag_reg <= opb_mag;
      dvd_raw_reg <= opa;
      dvs_raw_reg <= opb;
      signed_reg  <= is_divw;                                               // [RL5]
      neg_reg     <= is_divw && (opa[31] ^ opb[31]);
    end else if (ce && state_reg == wdu_pkg::ST_CALC) begin
      rem_reg <= diff[32] ? rem_sh[31:0] : diff[31:0];
      quo_reg <= {quo_reg[30:0], !diff[32]};
    end
  end

  // General registers, quotient wins over a bus write to the same index
  always_ff @(posedge aclk) begin
    if (ce && wr_gr) begin
      general_register[aw_addr_reg[6:2]] <= merge(general_register[aw_addr_reg[6:2]],
                                                  w_data_reg, w_strb_reg);
    end
    if (fin) begin
      general_register[insn_reg.dest_register_index] <= quot;               // [RL3]
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_issue;
    ce && issue;
  endsequence
  sequence s_calc_run;
    (state_reg == wdu_pkg::ST_CALC)[*8];
  endsequence

  property p_decode_start;
    s_issue |=> s_calc_run;
  endproperty
  a_decode_start: assert property (p_decode_start)  // [RL1] [RL2]
    else $error("decoded divide did not start");

  property p_carry_kept;
    (ce && !wr_xer) |=> xer_reg.carry_flag == $past(xer_reg.carry_flag);
  endproperty
  a_carry_kept: assert property (p_carry_kept)  // [RL12]
    else $error("carry flag changed by divide");

  property p_ov_hold;
    (fin && !insn_reg.ovf_enable && !wr_xer) |=> $stable(xer_reg);
  endproperty
  a_ov_hold: assert property (p_ov_hold)  // [RL10]
    else $error("overflow flags changed without enable");

  property p_ov_set;
    (fin && insn_reg.ovf_enable) |=> xer_reg.result_too_big_flag == $past(ovf)
      && (xer_reg.summary_ovf || !$past(ovf));
  endproperty
  a_ov_set: assert property (p_ov_set)  // [RL13]
    else $error("overflow flag wrong after divide");

  property p_cr_hold;
    (fin && !insn_reg.record_selector && !wr_cr) |=> $stable(cr_reg);
  endproperty
  a_cr_hold: assert property (p_cr_hold)  // [RL11]
    else $error("condition field changed without record");

  property p_cr_sign;
    (fin && insn_reg.record_selector) |=> cr_reg.negative_result_flag == $past(quot[31])
      && cr_reg.zero_result_flag == ($past(quot) == 32'h0)
      && cr_reg.summary_ovf == xer_reg.summary_ovf;
  endproperty
  a_cr_sign: assert property (p_cr_sign)  // [RL9] [RL14]
    else $error("condition field sign flags wrong");

  property p_udiv_value;
    (fin && !signed_reg && dvs_raw_reg != 32'h0) |-> quot == dvd_raw_reg / dvs_raw_reg;
  endproperty
  a_udiv_value: assert property (p_udiv_value)  // [RL7]
    else $error("unsigned quotient wrong");

  property p_sdiv_value;
    (fin && signed_reg && !ovf) |-> $signed(quot) == $signed(dvd_raw_reg) / $signed(dvs_raw_reg);
  endproperty
  a_sdiv_value: assert property (p_sdiv_value)  // [RL5]
    else $error("signed quotient wrong");

endmodule // wdu_word_divide_unit

`default_nettype wire

// [wdu_axi_master.sv]
// AXI4-Lite master model standing in for the issue logic of the core.
// Assumes one clock; the bench calls wr and rd, one transfer at a time.
`timescale 1ns/1ps
`default_nettype none

module wdu_axi_master (
  input  wire logic        aclk,
  output var  logic [11:0] awaddr,
  output var  logic        awvalid,
  input  wire logic        awready,
  output var  logic [31:0] wdata,
  output var  logic [3:0]  wstrb,
  output var  logic        wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output var  logic        bready,
  output var  logic [11:0] araddr,
  output var  logic        arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output var  logic        rready
);
  // ****************************************
  // Idle levels at time zero
  // ****************************************
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end

  // Write: address and data together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_t, w_t, b_t;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b_t = 1'b0;
    while (!b_t) begin
      @(negedge aclk);
      aw_t = awvalid & awready;
      w_t = wvalid & wready;
      b_t = bvalid;
      r = bresp;
      @(posedge aclk);
      // Released lines show garbage, not the old value
      if (aw_t) begin
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (w_t) begin
        wvalid <= 1'b0;
        wdata <= ~d;
      end
    end
    bready <= 1'b0;
  endtask

  // Read: address held until taken, rready until data seen
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_t, r_t;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r_t = 1'b0;
    while (!r_t) begin
      @(negedge aclk);
      ar_t = arvalid & arready;
      r_t = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ar_t) begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
    end
    rready <= 1'b0;
  endtask
endmodule // wdu_axi_master

`default_nettype wire

// [wdu_word_divide_unit_tb_top.sv]
// Self-checking bench of the word divide unit over its register bus.
// Assumes the master model drives every bus input; ce is high except while run_div holds it low.
`timescale 1ns/1ps
`default_nettype none

module wdu_word_divide_unit_tb_top;
  // ****************************************
  // Clock, reset and wiring
  // ****************************************
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq;
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  logic [31:0] v;
  logic [1:0] rs;

  always #20 aclk = ~aclk;

  wdu_word_divide_unit i_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .irq(irq));

  wdu_axi_master i_mst (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));

  // ****************************************
  // Checking helpers
  // ****************************************
  task automatic give_verdict();
    $display("mismatches %0d, comparisons %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Hang guard
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      give_verdict();
    end
  end

  // Divide word: dest 3, dividend 1, divisor 2
  function automatic logic [31:0] mk(input logic [8:0] xo, input logic oe, input logic rc);
    return {wdu_pkg::OPC_PRIMARY, 5'd3, 5'd1, 5'd2, oe, xo, rc};
  endfunction

  function automatic logic [11:0] gr(input logic [4:0] n);
    return {wdu_pkg::GR_PAGE, n, 2'b00};
  endfunction

  // One divide with preset flags, then quotient and flag checks
  task automatic run_div(input logic [8:0] xo, input logic [31:0] a, input logic [31:0] b,
                         input logic oe, input logic rc, input logic [31:0] xi);
    logic [31:0] q, xe;
    logic [3:0] cr;
    logic sg, ovf;
    int n;
    sg = (xo === wdu_pkg::XO_DIVW);
    ovf = (b == 0) || (sg && a == 32'h80000000 && b == 32'hffffffff);
    // Kept apart: a mixed conditional would turn the signed divide unsigned
    if (sg) q = $signed(a) / $signed(b);
    else q = a / b;
    xe = xi;
    if (oe) begin
      xe[30] = ovf;
      xe[31] = xi[31] | ovf;
    end
    cr = {$signed(q) < 0, $signed(q) > 0, q == 0, xe[31]};
    i_mst.wr(gr(5'd1), a, rs);
    i_mst.wr(gr(5'd2), b, rs);
    i_mst.wr(wdu_pkg::ADDR_XER, xi, rs);
    i_mst.wr(wdu_pkg::ADDR_CR0, 32'h5, rs);
    i_mst.wr(wdu_pkg::ADDR_INSN, mk(xo, oe, rc), rs);
    // Clock enable low freezes the divider, so it must still be busy after
    ce <= 1'b0;
    repeat (40) @(posedge aclk);
    ce <= 1'b1;
    i_mst.rd(wdu_pkg::ADDR_STAT, v, rs);
    chk(v, 32'h1);
    n = 0;
    while (v[0] !== 1'b0 && n < 60) begin
      i_mst.rd(wdu_pkg::ADDR_STAT, v, rs);
      n++;
    end
    // A divide still busy at the poll limit counts as a mismatch
    chk(v, 32'h0);
    i_mst.rd(gr(5'd3), v, rs);
    if (!ovf) chk(v, q);
    i_mst.rd(wdu_pkg::ADDR_XER, v, rs);
    chk(v, {xe[31:29], 29'h0});
    i_mst.rd(wdu_pkg::ADDR_CR0, v, rs);
    if (!rc) chk(v, 32'h5);
    else if (ovf) chk(v[0], xe[31]);
    else chk(v, {28'h0, cr});
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values of flag and interrupt registers
    for (int i = 0; i < 4; i++) begin
      i_mst.rd(wdu_pkg::ADDR_XER + 12'(4 * i), v, rs);
      chk(v, 32'h0);
    end
    chk(irq, 1'b0);
    // Unmapped place answers with an error
    i_mst.rd(12'h040, v, rs);
    chk(rs, wdu_pkg::RESP_SLVERR);
    i_mst.wr(12'h040, 32'h1, rs);
    chk(rs, wdu_pkg::RESP_SLVERR);
    // All four variants of each divide, overflow cases among them
    run_div(wdu_pkg::XO_DIVW, 32'hfffffff9, 32'h2, 1'b0, 1'b0, 32'h20000000);
    run_div(wdu_pkg::XO_DIVW, 32'hfffffff9, 32'h2, 1'b0, 1'b1, 32'h80000000);
    run_div(wdu_pkg::XO_DIVW, 32'h6, 32'h3, 1'b1, 1'b0, 32'he0000000);
    run_div(wdu_pkg::XO_DIVW, 32'h80000000, 32'hffffffff, 1'b1, 1'b1, 32'h0);
    run_div(wdu_pkg::XO_DIVW, 32'h9, 32'h0, 1'b0, 1'b1, 32'h20000000);
    run_div(wdu_pkg::XO_DIVWU, 32'h80000000, 32'h2, 1'b0, 1'b1, 32'h20000000);
    run_div(wdu_pkg::XO_DIVWU, 32'hfffffff0, 32'h1, 1'b1, 1'b1, 32'h0);
    run_div(wdu_pkg::XO_DIVWU, 32'h5, 32'h0, 1'b1, 1'b0, 32'h20000000);
    run_div(wdu_pkg::XO_DIVWU, 32'h0, 32'h2, 1'b0, 1'b0, 32'ha0000000);
    // Interrupt: clear, unmask illegal, raise, clear, then masked
    i_mst.wr(wdu_pkg::ADDR_ISTAT, 32'h7, rs);
    i_mst.wr(wdu_pkg::ADDR_IMASK, 32'h4, rs);
    chk(irq, 1'b0);
    i_mst.wr(wdu_pkg::ADDR_INSN, mk(9'h1e9, 1'b0, 1'b0), rs);
    i_mst.rd(wdu_pkg::ADDR_STAT, v, rs);
    chk(v, 32'h0);
    chk(irq, 1'b1);
    i_mst.wr(wdu_pkg::ADDR_ISTAT, 32'h4, rs);
    chk(irq, 1'b0);
    i_mst.wr(wdu_pkg::ADDR_IMASK, 32'h0, rs);
    i_mst.wr(wdu_pkg::ADDR_INSN, mk(wdu_pkg::XO_DIVW, 1'b0, 1'b0) ^ 32'h4000000, rs);
    i_mst.rd(wdu_pkg::ADDR_ISTAT, v, rs);
    chk(v & 32'h4, 32'h4);
    chk(irq, 1'b0);
    give_verdict();
  end
endmodule // wdu_word_divide_unit_tb_top

`default_nettype wire
